// ==== rtl/sspc_cfg.svh ====
// register offsets, field positions, reset values, mode codes and rate counts
`ifndef SSPC_CFG_SVH
`define SSPC_CFG_SVH
`define SSPC_OFS_STATUS 12'h18F
`define SSPC_OFS_CTRL1 12'h190
`define SSPC_OFS_CTRL2 12'h191
`define SSPC_OFS_BUF 12'h193
`define SSPC_OFS_DIV 12'h194
`define SSPC_CTRL1_RST 8'h00
`define SSPC_CTRL2_RST 8'h00
`define SSPC_BUF_RST 8'h00
`define SSPC_DIV_RST 8'h00
`define SSPC_PIN_IDLE 5'h1C
`define SSPC_C1_OVF 6
`define SSPC_C1_EN 5
`define SSPC_C1_CKP 4
`define SSPC_C2_GENERAL_CALL_ENABLE 7
`define SSPC_C2_ACK_RECEIVED_STATUS 6
`define SSPC_C2_ACK_VALUE_BIT 5
`define SSPC_C2_ACK_SEQUENCE_TRIGGER 4
`define SSPC_C2_HOST_RECEIVE_TRIGGER 3
`define SSPC_C2_PEN 2
`define SSPC_C2_RESTART_TRIGGER 1
`define SSPC_C2_SEN 0
`define SSPC_ST_TXACT 2
`define SSPC_ST_FULL 0
`define SSPC_M_I2C_C10_EV 4'hF
`define SSPC_M_I2C_C7_EV 4'hE
`define SSPC_M_I2C_FW 4'hB
`define SSPC_M_SPI_H_DIV 4'hA
`define SSPC_M_I2C_H 4'h8
`define SSPC_M_I2C_C10 4'h7
`define SSPC_M_I2C_C7 4'h6
`define SSPC_M_SPI_C_NOSEL 4'h5
`define SSPC_M_SPI_C_SEL 4'h4
`define SSPC_M_SPI_H_TMR 4'h3
`define SSPC_M_SPI_H_64 4'h2
`define SSPC_M_SPI_H_16 4'h1
`define SSPC_M_SPI_H_4 4'h0
`define SSPC_Q_DIV4 9'h001
`define SSPC_Q_DIV16 9'h004
`define SSPC_Q_DIV64 9'h010
`endif

// ==== rtl/sspc_pkg.sv ====
// types of the serial port control block
package sspc_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_SPI, ST_START, ST_RESTART, ST_STOP, ST_TX, ST_RX, ST_ACK} sspc_state_t;
endpackage

// ==== rtl/sspc_core.sv ====
// synchronous serial port control: spi host/client, i2c host/client
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "sspc_cfg.svh"
module sspc_core (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // on-chip timer pulse
  input wire logic timer_two_output,
  // spi pins
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_n,
  input wire logic sdi_pin,
  output logic sdo_pin,
  output logic sdo_pin_oe_n,
  input wire logic client_select_pin_n,
  // i2c pins
  input wire logic bus_clock_pin_in,
  output logic bus_clock_pin_out,
  output logic bus_clock_pin_oe_n,
  input wire logic bus_data_pin_in,
  output logic bus_data_pin_out,
  output logic bus_data_pin_oe_n,
  // status
  output logic port_owns_pins,
  output logic cond_event_pulse
);
  // ==========================================================
  // state
  logic [4:0] sync_a_ff, sync_b_ff, prev_ff, nxt_prev;
  logic en_ff, ckp_ff, ovf_ff, nxt_en, nxt_ckp, nxt_ovf;
  logic [3:0] mode_ff, nxt_mode;
  logic general_call_enable_ff, ack_received_status_ff, ack_value_bit_ff, ack_sequence_trigger_ff, host_receive_trigger_ff, pen_ff, restart_trigger_ff, sen_ff;
  logic nxt_general_call_enable, nxt_ack_received_status, nxt_ack_value_bit, nxt_ack_sequence_trigger, nxt_host_receive_trigger, nxt_pen, nxt_restart_trigger, nxt_sen;
  logic [7:0] buf_ff, div_ff, shift_ff, rdata_ff, nxt_buf, nxt_div, nxt_shift, nxt_rdata;
  logic full_ff, samp_ff, sck_ff, qhalf_ff, scl_low_ff, sda_low_ff, matched_ff, is_addr_ff, evt_ff;
  logic nxt_full, nxt_samp, nxt_sck, nxt_qhalf, nxt_scl_low, nxt_sda_low, nxt_matched, nxt_is_addr, nxt_evt;
  logic [8:0] qcnt_ff, nxt_qcnt, qlim;
  logic [1:0] ph_ff, nxt_ph;
  logic [3:0] bit_ff, nxt_bit;
  sspc_pkg::sspc_state_t st_ff, nxt_st;
  // bit 7 of control one is not stored
  localparam logic [7:0] ctrl1_rst = `SSPC_CTRL1_RST;
  // decode and events
  logic spi_host, spi_cli, i2c_host, i2c_cli, busy, qtick, edge_t, lead, trail, sel;
  logic i2_start, i2_stop, scl_rise, scl_fall, spi_cli_done, sda_s, scl_s, sck_s, sdi_s, ss_s;
  logic wr_c1, wr_c2, wr_buf, wr_div, bit_out;

  // ==========================================================
  // pin synchronisers
  assign sck_s = sync_b_ff[0];
  assign sdi_s = sync_b_ff[1];
  assign ss_s = sync_b_ff[2];
  assign scl_s = sync_b_ff[3];
  assign sda_s = sync_b_ff[4];
  assign nxt_prev = sync_b_ff;

  // ==========================================================
  // mode decode
  always_comb
  begin
    spi_host = (mode_ff == `SSPC_M_SPI_H_4) || (mode_ff == `SSPC_M_SPI_H_16) || (mode_ff == `SSPC_M_SPI_H_64)
      || (mode_ff == `SSPC_M_SPI_H_TMR) || (mode_ff == `SSPC_M_SPI_H_DIV);
    spi_cli = (mode_ff == `SSPC_M_SPI_C_SEL) || (mode_ff == `SSPC_M_SPI_C_NOSEL);
    // firmware host keeps both hardware engines idle
    i2c_host = (mode_ff == `SSPC_M_I2C_H);
    i2c_cli = (mode_ff == `SSPC_M_I2C_C7) || (mode_ff == `SSPC_M_I2C_C10)
      || (mode_ff == `SSPC_M_I2C_C7_EV) || (mode_ff == `SSPC_M_I2C_C10_EV);
    if (mode_ff == `SSPC_M_SPI_H_4)
    begin
      qlim = `SSPC_Q_DIV4;
    end
    else if (mode_ff == `SSPC_M_SPI_H_16)
    begin
      qlim = `SSPC_Q_DIV16;
    end
    else if (mode_ff == `SSPC_M_SPI_H_64)
    begin
      qlim = `SSPC_Q_DIV64;
    end
    else
    begin
      qlim = {1'b0, div_ff} + 9'h001;
    end
    busy = (st_ff != sspc_pkg::ST_IDLE);
    sel = (mode_ff == `SSPC_M_SPI_C_NOSEL) || !ss_s;
    lead = (sck_s != prev_ff[0]) && (prev_ff[0] == ckp_ff);
    trail = (sck_s != prev_ff[0]) && (sck_s == ckp_ff);
    i2_start = scl_s && prev_ff[3] && prev_ff[4] && !sda_s;
    i2_stop = scl_s && prev_ff[3] && !prev_ff[4] && sda_s;
    scl_rise = scl_s && !prev_ff[3];
    scl_fall = !scl_s && prev_ff[3];
    wr_c1 = reg_wr && (reg_addr == `SSPC_OFS_CTRL1);
    wr_c2 = reg_wr && (reg_addr == `SSPC_OFS_CTRL2);
    wr_buf = reg_wr && (reg_addr == `SSPC_OFS_BUF);
    wr_div = reg_wr && (reg_addr == `SSPC_OFS_DIV);
  end

  // ==========================================================
  // next state
  always_comb
  begin
    nxt_en = en_ff;
    nxt_ckp = ckp_ff;
    nxt_ovf = ovf_ff;
    nxt_mode = mode_ff;
    nxt_general_call_enable = general_call_enable_ff;
    nxt_ack_received_status = ack_received_status_ff;
    nxt_ack_value_bit = ack_value_bit_ff;
    nxt_ack_sequence_trigger = ack_sequence_trigger_ff;
    nxt_host_receive_trigger = host_receive_trigger_ff;
    nxt_pen = pen_ff;
    nxt_restart_trigger = restart_trigger_ff;
    nxt_sen = sen_ff;
    nxt_buf = buf_ff;
    nxt_div = div_ff;
    nxt_shift = shift_ff;
    nxt_full = full_ff;
    nxt_samp = samp_ff;
    nxt_sck = sck_ff;
    nxt_qhalf = qhalf_ff;
    nxt_scl_low = scl_low_ff;
    nxt_sda_low = sda_low_ff;
    nxt_matched = matched_ff;
    nxt_is_addr = is_addr_ff;
    nxt_evt = 1'b0;
    nxt_qcnt = qcnt_ff;
    nxt_ph = ph_ff;
    nxt_bit = bit_ff;
    nxt_st = st_ff;
    nxt_rdata = 8'h00;
    qtick = 1'b0;
    edge_t = 1'b0;
    spi_cli_done = 1'b0;
    bit_out = 1'b1;
    // register reads: data in the next cycle only
    if (reg_rd)
    begin
      if (reg_addr == `SSPC_OFS_STATUS)
      begin
        nxt_rdata = {5'h00, (st_ff == sspc_pkg::ST_TX), 1'b0, full_ff};
      end
      else if (reg_addr == `SSPC_OFS_CTRL1)
      begin
        nxt_rdata = {1'b0, ovf_ff, en_ff, ckp_ff, mode_ff};
      end
      else if (reg_addr == `SSPC_OFS_CTRL2)
      begin
        nxt_rdata = {general_call_enable_ff, ack_received_status_ff, ack_value_bit_ff, ack_sequence_trigger_ff, host_receive_trigger_ff, pen_ff, restart_trigger_ff, sen_ff};
      end
      else if (reg_addr == `SSPC_OFS_BUF)
      begin
        nxt_rdata = buf_ff;
        nxt_full = 1'b0;
      end
      else if (reg_addr == `SSPC_OFS_DIV)
      begin
        nxt_rdata = div_ff;
      end
    end
    // register writes
    if (wr_c1)
    begin
      nxt_ovf = reg_wdata[`SSPC_C1_OVF];
      nxt_en = reg_wdata[`SSPC_C1_EN];
      nxt_ckp = reg_wdata[`SSPC_C1_CKP];
      nxt_mode = reg_wdata[3:0];
    end
    if (wr_c2)
    begin
      nxt_general_call_enable = reg_wdata[`SSPC_C2_GENERAL_CALL_ENABLE];
      nxt_ack_received_status = reg_wdata[`SSPC_C2_ACK_RECEIVED_STATUS];
      nxt_ack_value_bit = reg_wdata[`SSPC_C2_ACK_VALUE_BIT];
      if (!busy)
      begin
        nxt_ack_sequence_trigger = reg_wdata[`SSPC_C2_ACK_SEQUENCE_TRIGGER];
        nxt_host_receive_trigger = reg_wdata[`SSPC_C2_HOST_RECEIVE_TRIGGER];
        nxt_pen = reg_wdata[`SSPC_C2_PEN];
        nxt_restart_trigger = reg_wdata[`SSPC_C2_RESTART_TRIGGER];
        nxt_sen = reg_wdata[`SSPC_C2_SEN];
      end
    end
    if (wr_div)
    begin
      nxt_div = reg_wdata;
    end
    // quarter-bit time base
    if (!busy)
    begin
      nxt_qcnt = 9'h000;
    end
    else if (qcnt_ff >= qlim - 9'h001)
    begin
      nxt_qcnt = 9'h000;
      qtick = 1'b1;
    end
    else
    begin
      nxt_qcnt = qcnt_ff + 9'h001;
    end
    if (mode_ff == `SSPC_M_SPI_H_TMR)
    begin
      edge_t = timer_two_output && busy;
    end
    else
    begin
      edge_t = qtick && qhalf_ff;
    end
    if (qtick)
    begin
      nxt_qhalf = !qhalf_ff;
    end
    // engines
    case (st_ff)
      sspc_pkg::ST_IDLE:
      begin
        nxt_qhalf = 1'b0;
        nxt_ph = 2'h0;
        nxt_bit = spi_cli || i2c_cli ? nxt_bit : 4'h0;
        if (spi_host)
        begin
          nxt_sck = ckp_ff;
          if (wr_buf)
          begin
            nxt_shift = reg_wdata;
            nxt_st = sspc_pkg::ST_SPI;
          end
        end
        else if (i2c_host)
        begin
          if (sen_ff)
          begin
            nxt_st = sspc_pkg::ST_START;
          end
          else if (restart_trigger_ff)
          begin
            nxt_st = sspc_pkg::ST_RESTART;
          end
          else if (pen_ff)
          begin
            nxt_st = sspc_pkg::ST_STOP;
          end
          else if (wr_buf)
          begin
            nxt_shift = reg_wdata;
            nxt_full = 1'b1;
            nxt_st = sspc_pkg::ST_TX;
          end
          else if (host_receive_trigger_ff)
          begin
            nxt_st = sspc_pkg::ST_RX;
          end
          else if (ack_sequence_trigger_ff)
          begin
            nxt_st = sspc_pkg::ST_ACK;
          end
        end
        else if (spi_cli && wr_buf)
        begin
          nxt_shift = reg_wdata;
        end
      end
      sspc_pkg::ST_SPI:
      begin
        if (edge_t)
        begin
          nxt_sck = !sck_ff;
          if (sck_ff == ckp_ff)
          begin
            nxt_samp = sdi_s;
          end
          else
          begin
            nxt_shift = {shift_ff[6:0], samp_ff};
            nxt_bit = bit_ff + 4'h1;
            if (bit_ff == 4'h7)
            begin
              nxt_buf = {shift_ff[6:0], samp_ff};
              nxt_full = 1'b1;
              nxt_st = sspc_pkg::ST_IDLE;
            end
          end
        end
      end
      sspc_pkg::ST_START, sspc_pkg::ST_RESTART, sspc_pkg::ST_STOP:
      begin
        if (qtick)
        begin
          nxt_ph = ph_ff + 2'h1;
          if (st_ff == sspc_pkg::ST_START)
          begin
            nxt_sda_low = 1'b1;
            nxt_scl_low = (ph_ff == 2'h3);
          end
          else if (st_ff == sspc_pkg::ST_RESTART)
          begin
            nxt_sda_low = ph_ff[1];
            nxt_scl_low = (ph_ff == 2'h0) || (ph_ff == 2'h3);
          end
          else
          begin
            nxt_sda_low = !ph_ff[1];
            nxt_scl_low = (ph_ff == 2'h0);
          end
          if (ph_ff == 2'h3)
          begin
            nxt_sen = (st_ff == sspc_pkg::ST_START) ? 1'b0 : sen_ff;
            nxt_restart_trigger = (st_ff == sspc_pkg::ST_RESTART) ? 1'b0 : restart_trigger_ff;
            nxt_pen = (st_ff == sspc_pkg::ST_STOP) ? 1'b0 : pen_ff;
            nxt_st = sspc_pkg::ST_IDLE;
          end
        end
      end
      sspc_pkg::ST_TX, sspc_pkg::ST_RX, sspc_pkg::ST_ACK:
      begin
        if (st_ff == sspc_pkg::ST_TX)
        begin
          bit_out = (bit_ff == 4'h8) || shift_ff[7];
        end
        else if (st_ff == sspc_pkg::ST_ACK)
        begin
          bit_out = ack_value_bit_ff;
        end
        if (qtick)
        begin
          nxt_ph = ph_ff + 2'h1;
          if (ph_ff == 2'h0)
          begin
            nxt_sda_low = !bit_out;
          end
          else if (ph_ff == 2'h1)
          begin
            nxt_scl_low = 1'b0;
          end
          else if (ph_ff == 2'h2)
          begin
            if (st_ff == sspc_pkg::ST_RX)
            begin
              nxt_shift = {shift_ff[6:0], sda_s};
            end
            else if ((st_ff == sspc_pkg::ST_TX) && (bit_ff == 4'h8))
            begin
              nxt_ack_received_status = sda_s;
            end
          end
          else
          begin
            nxt_scl_low = 1'b1;
            nxt_bit = bit_ff + 4'h1;
            if (st_ff == sspc_pkg::ST_TX)
            begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              if (bit_ff == 4'h8)
              begin
                nxt_full = 1'b0;
                nxt_st = sspc_pkg::ST_IDLE;
              end
            end
            else if (st_ff == sspc_pkg::ST_RX)
            begin
              if (bit_ff == 4'h7)
              begin
                nxt_buf = shift_ff;
                nxt_full = 1'b1;
                nxt_host_receive_trigger = 1'b0;
                nxt_st = sspc_pkg::ST_IDLE;
              end
            end
            else
            begin
              nxt_ack_sequence_trigger = 1'b0;
              nxt_st = sspc_pkg::ST_IDLE;
            end
          end
        end
      end
      default:
      begin
        nxt_st = sspc_pkg::ST_IDLE;
      end
    endcase
    // spi client shifter on the pin clock
    if (spi_cli)
    begin
      if (!sel)
      begin
        nxt_bit = 4'h0;
      end
      else if (lead)
      begin
        nxt_samp = sdi_s;
      end
      else if (trail)
      begin
        nxt_shift = {shift_ff[6:0], samp_ff};
        nxt_bit = bit_ff + 4'h1;
        if (bit_ff == 4'h7)
        begin
          spi_cli_done = 1'b1;
          nxt_bit = 4'h0;
          if (full_ff)
          begin
            nxt_ovf = 1'b1;
          end
          else
          begin
            nxt_buf = {shift_ff[6:0], samp_ff};
            nxt_full = 1'b1;
          end
        end
      end
    end
    // i2c client receiver
    if (i2c_cli)
    begin
      if (i2_start || i2_stop)
      begin
        nxt_bit = 4'h0;
        nxt_is_addr = i2_start;
        nxt_matched = 1'b0;
        nxt_sda_low = 1'b0;
        nxt_evt = mode_ff[3];
      end
      else if (scl_rise && (bit_ff < 4'h8))
      begin
        nxt_shift = {shift_ff[6:0], sda_s};
        nxt_bit = bit_ff + 4'h1;
      end
      else if (scl_fall && (bit_ff == 4'h8))
      begin
        nxt_bit = 4'h9;
        if (is_addr_ff)
        begin
          nxt_is_addr = 1'b0;
          if (((shift_ff[7:1] == div_ff[7:1]) || (general_call_enable_ff && (shift_ff == 8'h00))) && !shift_ff[0])
          begin
            nxt_matched = 1'b1;
            nxt_sda_low = 1'b1;
          end
        end
        else if (matched_ff)
        begin
          if (full_ff)
          begin
            nxt_ovf = 1'b1;
          end
          else
          begin
            nxt_buf = shift_ff;
            nxt_full = 1'b1;
            nxt_sda_low = 1'b1;
          end
        end
      end
      else if (scl_fall && (bit_ff == 4'h9))
      begin
        nxt_bit = 4'h0;
        nxt_sda_low = 1'b0;
      end
    end
    // disabled port: engines parked, pins released
    if (!en_ff)
    begin
      nxt_st = sspc_pkg::ST_IDLE;
      nxt_full = 1'b0;
      nxt_bit = 4'h0;
      nxt_scl_low = 1'b0;
      nxt_sda_low = 1'b0;
      nxt_matched = 1'b0;
      nxt_sck = ckp_ff;
      nxt_evt = 1'b0;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      // idle pin levels, so no false edge follows reset
      sync_a_ff <= `SSPC_PIN_IDLE;
      sync_b_ff <= `SSPC_PIN_IDLE;
      prev_ff <= `SSPC_PIN_IDLE;
      {ovf_ff, en_ff, ckp_ff, mode_ff} <= ctrl1_rst[6:0];
      {general_call_enable_ff, ack_received_status_ff, ack_value_bit_ff, ack_sequence_trigger_ff, host_receive_trigger_ff, pen_ff, restart_trigger_ff, sen_ff} <= `SSPC_CTRL2_RST;
      buf_ff <= `SSPC_BUF_RST;
      div_ff <= `SSPC_DIV_RST;
      shift_ff <= 8'h00;
      rdata_ff <= 8'h00;
      {full_ff, samp_ff, sck_ff, qhalf_ff, scl_low_ff, sda_low_ff, matched_ff, is_addr_ff, evt_ff} <= 9'h000;
      qcnt_ff <= 9'h000;
      ph_ff <= 2'h0;
      bit_ff <= 4'h0;
      st_ff <= sspc_pkg::ST_IDLE;
    end
    else if (clk_en)
    begin
      sync_a_ff <= {bus_data_pin_in, bus_clock_pin_in, client_select_pin_n, sdi_pin, serial_clock_pin_in};
      sync_b_ff <= sync_a_ff;
      prev_ff <= nxt_prev;
      {ovf_ff, en_ff, ckp_ff, mode_ff} <= {nxt_ovf, nxt_en, nxt_ckp, nxt_mode};
      {general_call_enable_ff, ack_received_status_ff, ack_value_bit_ff, ack_sequence_trigger_ff} <= {nxt_general_call_enable, nxt_ack_received_status, nxt_ack_value_bit, nxt_ack_sequence_trigger};
      {host_receive_trigger_ff, pen_ff, restart_trigger_ff, sen_ff} <= {nxt_host_receive_trigger, nxt_pen, nxt_restart_trigger, nxt_sen};
      buf_ff <= nxt_buf;
      div_ff <= nxt_div;
      shift_ff <= nxt_shift;
      rdata_ff <= nxt_rdata;
      {full_ff, samp_ff, sck_ff, qhalf_ff} <= {nxt_full, nxt_samp, nxt_sck, nxt_qhalf};
      {scl_low_ff, sda_low_ff, matched_ff, is_addr_ff, evt_ff} <= {nxt_scl_low, nxt_sda_low, nxt_matched,
        nxt_is_addr, nxt_evt};
      qcnt_ff <= nxt_qcnt;
      ph_ff <= nxt_ph;
      bit_ff <= nxt_bit;
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // pin drive
  assign reg_rdata = rdata_ff;
  assign port_owns_pins = en_ff;
  assign cond_event_pulse = evt_ff;
  assign serial_clock_pin_out = sck_ff;
  assign serial_clock_pin_oe_n = !(en_ff && spi_host);
  assign sdo_pin = shift_ff[7];
  assign sdo_pin_oe_n = !(en_ff && (spi_host || (spi_cli && sel)));
  assign bus_clock_pin_out = 1'b0;
  assign bus_data_pin_out = 1'b0;
  assign bus_clock_pin_oe_n = !(en_ff && ((i2c_host && scl_low_ff) || (i2c_cli && !ckp_ff)));
  assign bus_data_pin_oe_n = !(en_ff && (i2c_host || i2c_cli) && sda_low_ff);

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst || !clk_en);

  spi_cli_ovf_a: assert property (spi_cli_done && full_ff |=> ovf_ff && (buf_ff == $past(buf_ff)))
    else $error("spi client overflow not flagged or buffer overwritten");
  i2c_cli_ovf_a: assert property (i2c_cli && en_ff && scl_fall && bit_ff == 4'h8 && matched_ff && !is_addr_ff
    && full_ff |=> ovf_ff)
    else $error("i2c receive overflow not flagged");
  host_no_ovf_a: assert property ((spi_host || i2c_host) && !wr_c1 |=> !$rose(ovf_ff))
    else $error("overflow set in host mode");
  pins_release_a: assert property (!en_ff |-> serial_clock_pin_oe_n && sdo_pin_oe_n && bus_clock_pin_oe_n
    && bus_data_pin_oe_n)
    else $error("pin driven while port disabled");
  spi_idle_a: assert property (en_ff && spi_host && st_ff == sspc_pkg::ST_IDLE ##1 $stable(ckp_ff)
    |-> serial_clock_pin_out == ckp_ff)
    else $error("spi idle clock level wrong");
  cli_stretch_a: assert property (en_ff && i2c_cli && !ckp_ff |-> !bus_clock_pin_oe_n)
    else $error("client did not stretch clock");
  stop_run_a: assert property (i2c_host && en_ff && st_ff == sspc_pkg::ST_IDLE && !sen_ff && !restart_trigger_ff && pen_ff
    |=> st_ff == sspc_pkg::ST_STOP)
    else $error("stop trigger not acted on");
  trig_block_a: assert property (busy && wr_c2 && !sen_ff |=> !sen_ff)
    else $error("start trigger set while active");
endmodule // sspc_core

// ==== testbench/sspc_peer.sv ====
// spi peer device answering a host transfer with a preset byte
`timescale 1ns/1ps
module sspc_peer (
  // clock and host pins
  input wire logic ref_clk,
  input wire logic sck,
  input wire logic cpol,
  input wire logic load,
  input wire logic [7:0] tx_byte,
  // data towards host
  output logic sdi
);
  logic [3:0] idx_ff = 4'h8;
  logic sck_ff = 1'b0;
  // =====================================
  // msb first, next bit after each trailing edge
  always @(posedge ref_clk)
  begin
    sck_ff <= sck;
    if (load)
      idx_ff <= 4'h0;
    else if (sck_ff != sck && sck == cpol && idx_ff < 4'h8)
      idx_ff <= idx_ff + 4'h1;
  end
  // outside a frame the line keeps changing
  assign sdi = (idx_ff < 4'h8) ? tx_byte[3'h7 - idx_ff[2:0]] : ~sck;
endmodule // sspc_peer

// ==== testbench/tb.sv ====
// self-checking bench of the serial port control block
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_d = 1'b0;
  logic load = 1'b0;
  logic [7:0] reg_rdata, last_rd, exp_q[$], msk_q[$];
  logic [7:0] peer_byte = 8'h00;
  logic sck, sck_oe_n, sdi, scl_oe_n, sda_oe_n, owns;
  logic [7:0] modes [5] = '{8'h00, 8'h01, 8'h0A, 8'h03, 8'h02};
  logic [7:0] halfs [5] = '{8'h02, 8'h08, 8'h08, 8'h06, 8'h20};
  logic cli_sck = 1'b0;
  logic cli_sdi = 1'b0;
  logic cli_on = 1'b0;
  logic sda_ext = 1'b1;
  logic evt;
  logic [7:0] cb;
  int evt_n = 0;
  int tcnt = 0;
  logic [7:0] trig [5] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h04};
  int err_total = 0;
  int total_checks = 0;
  int hp;
  always #2.5 ref_clk = ~ref_clk;
  sspc_core i_dut (.ref_clk(ref_clk), .srst(srst), .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_two_output(tcnt == 0),
    .serial_clock_pin_in(cli_sck), .serial_clock_pin_out(sck), .serial_clock_pin_oe_n(sck_oe_n),
    .sdi_pin(cli_on ? cli_sdi : sdi), .sdo_pin(), .sdo_pin_oe_n(), .client_select_pin_n(1'b1),
    .bus_clock_pin_in(scl_oe_n), .bus_clock_pin_out(), .bus_clock_pin_oe_n(scl_oe_n),
    .bus_data_pin_in(sda_oe_n & sda_ext), .bus_data_pin_out(), .bus_data_pin_oe_n(sda_oe_n),
    .port_owns_pins(owns), .cond_event_pulse(evt));
  // timer pulse every six cycles, event pulse counter
  always @(posedge ref_clk)
  begin
    tcnt <= (tcnt + 1) % 6;
    evt_n <= evt_n + int'(evt);
  end
  sspc_peer i_peer (.ref_clk(ref_clk), .sck(sck), .cpol(1'b1), .load(load), .tx_byte(peer_byte), .sdi(sdi));
  // =====================================
  // checks and verdict
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    if (rd_d)
    begin
      last_rd = reg_rdata;
      if (msk_q[0] != 8'h00)
        cmp("reg_rdata", exp_q[0] & msk_q[0], reg_rdata & msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    rd_d <= reg_rd;
  end
  // =====================================
  // register bus
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic cli_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge ref_clk);
      cli_sdi <= b[i];
      repeat (4) @(posedge ref_clk);
      cli_sck <= 1'b1;
      repeat (4) @(posedge ref_clk);
      cli_sck <= 1'b0;
    end
    repeat (5) @(posedge ref_clk);
  endtask
  task automatic sda_pulse();
    sda_ext <= 1'b0;
    repeat (6) @(posedge ref_clk);
    sda_ext <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    print_verdict();
  end
  // =====================================
  // test sequence
  initial
  begin
    hp = $urandom(93186);
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    rd(12'h190, 8'h00, 8'hFF);
    rd(12'h191, 8'h00, 8'hFF);
    wr(12'h1A0, 8'h5A);
    rd(12'h1A0, 8'h00, 8'hFF);
    wr(12'h194, 8'h03);
    for (int k = 0; k < 5; k++)
    begin
      wr(12'h190, 8'h30 | modes[k]);
      repeat (4) @(posedge ref_clk);
      cmp("serial_clock_pin_out", 8'h01, {7'h00, sck});
      cmp("port_owns_pins", 8'h01, {7'h00, owns});
      peer_byte <= 8'($urandom);
      load <= 1'b1;
      @(posedge ref_clk);
      load <= 1'b0;
      wr(12'h193, peer_byte);
      for (int i = 0; i < 200 && sck !== 1'b0; i++) @(posedge ref_clk);
      for (hp = 0; hp < 200 && sck === 1'b0; hp++) @(posedge ref_clk);
      cmp("sck half period", halfs[k], 8'(hp));
      repeat (16 * hp + 20) @(posedge ref_clk);
      rd(12'h190, 8'h00, 8'h40);
    end
    rd(12'h193, peer_byte, 8'hFF);
    wr(12'h190, 8'h28);
    wr(12'h194, 8'h01);
    for (int k = 0; k < 5; k++)
    begin
      wr(12'h191, trig[k]);
      for (int i = 0; i < 60; i++)
      begin
        rd(12'h191, 8'h00, 8'h00);
        if ((last_rd & 8'h1F) == 8'h00)
          break;
      end
      rd(12'h191, 8'h00, trig[k]);
    end
    wr(12'h193, 8'hA5);
    repeat (120) @(posedge ref_clk);
    rd(12'h191, 8'h40, 8'h40);
    wr(12'h190, 8'h26);
    repeat (6) @(posedge ref_clk);
    cmp("bus_clock_pin_oe_n", 8'h00, {7'h00, scl_oe_n});
    wr(12'h190, 8'h36);
    repeat (6) @(posedge ref_clk);
    cmp("bus_clock_pin_oe_n", 8'h01, {7'h00, scl_oe_n});
    sda_pulse();
    wr(12'h190, 8'h3E);
    sda_pulse();
    cmp("cond_event_pulse", 8'h02, 8'(evt_n));
    wr(12'h190, 8'h3B);
    wr(12'h191, 8'h01);
    repeat (20) @(posedge ref_clk);
    cmp("bus_data_pin_oe_n", 8'h01, {7'h00, sda_oe_n});
    wr(12'h190, 8'h00);
    repeat (4) @(posedge ref_clk);
    cmp("port_owns_pins", 8'h00, {7'h00, owns});
    cmp("serial_clock_pin_oe_n", 8'h01, {7'h00, sck_oe_n});
    // spi client: second byte with buffer full overflows
    cli_on <= 1'b1;
    wr(12'h190, 8'h25);
    cb = 8'($urandom);
    cli_byte(cb);
    cli_byte(~cb);
    rd(12'h190, 8'h65, 8'hFF);
    rd(12'h193, cb, 8'hFF);
    print_verdict();
  end
endmodule // tb
